/* rtl/rss_params.svh */
`ifndef RSS_PARAMS_SVH
`define RSS_PARAMS_SVH

// Register byte offsets on the AXI4-Lite port
`define RSS_ADDR_SYSCTL     8'h00
`define RSS_ADDR_DBGFLAG    8'h04
`define RSS_ADDR_BO_ENABLE  8'h08
`define RSS_ADDR_CLKCTL     8'h0c
`define RSS_ADDR_IRQ_STATUS 8'h10
`define RSS_ADDR_IRQ_ENABLE 8'h14
`define RSS_ADDR_IRQ_CLEAR  8'h18
`define RSS_ADDR_RST_CAUSE  8'h1c

// Field positions
`define RSS_SC_SWRST        0
`define RSS_DF_PGMEN        1
`define RSS_CLK_FAIL_BIT    4
`define RSS_IRQ_XTAL_BIT    3

// Reset values
`define RSS_RESET_VECTOR    16'h8000
`define RSS_IRQ_RESET       4'h0
`define RSS_BO_EN_RESET     3'h0
`define RSS_CAUSE_POR       4'h1

// Timing counts in system clock cycles
`define RSS_EXT_MIN_LOW     4
`define RSS_HOLD_CYCLES     4
`define RSS_POR_DELAY       4096
`define RSS_XTAL_FAIL_MIN   2

// Supply thresholds in monitor codes
`define RSS_POR_THRESHOLD   8'h60
`define RSS_BO_THRESHOLDS   {8'h70, 8'h70, 8'h70}

`endif

/* rtl/rss_pkg.sv */
package rss_pkg;

  // Reset sequencer states
  typedef enum {RSS_ST_POR, RSS_ST_HOLD, RSS_ST_RUN} rss_state_e;

  // Master clock source encoding
  typedef enum logic [1:0] {
    RSS_CLK_XTAL = 2'h0,
    RSS_CLK_RC   = 2'h1,
    RSS_CLK_EXT  = 2'h2
  } rss_clk_e;

  // Digitised supply level from the on-chip monitor
  typedef logic [7:0] rss_level_t;

endpackage

/* rtl/rss_sync_qualify.sv */
`include "rss_params.svh"

// Two-flop synchroniser followed by a minimum-width qualifier
module rss_sync_qualify
  import rss_pkg::*;
  #(parameter int unsigned MIN_CYCLES = 4,
    parameter logic        ACTIVE_LOW = 1'b1)
  (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic async_in,
    output logic      active
  );

  localparam int unsigned   CW   = $clog2(MIN_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(MIN_CYCLES);

  logic          meta;          // First stage, read only by sync
  logic          sync;          // Second stage, safe to use
  logic          level;         // Input asserted after polarity fix
  logic [CW-1:0] run_cnt;       // Consecutive asserted samples
  logic [CW-1:0] next_run_cnt;
  logic          next_active;

  assign level = sync ^ ACTIVE_LOW;

  // Count consecutive asserted samples, saturating at the minimum
  always_comb
  begin
    if (!level)
      next_run_cnt = '0;
    else if (run_cnt == LAST)
      next_run_cnt = LAST;
    else
      next_run_cnt = run_cnt + 1'b1;
    next_active = (next_run_cnt == LAST);
  end

  // Short glitches never reach the count, so noise cannot reset the chip
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta    <= ACTIVE_LOW;
      sync    <= ACTIVE_LOW;
      run_cnt <= '0;
      active  <= 1'b0;
    end
    else
    begin
      meta    <= async_in;
      sync    <= meta;
      run_cnt <= next_run_cnt;
      active  <= next_active;
    end
  end

endmodule

/* rtl/rss_supervisor.sv */
`include "rss_params.svh"

module rss_supervisor
  import rss_pkg::*;
  #(parameter int unsigned      POR_DELAY_CYCLES = `RSS_POR_DELAY,
    parameter rss_level_t       POR_THRESHOLD    = `RSS_POR_THRESHOLD,
    parameter logic [2:0][7:0]  BO_THRESHOLDS    = `RSS_BO_THRESHOLDS)
  (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire rss_level_t  core_supply_level,
    input  wire rss_level_t  analog_supply_level,
    input  wire rss_level_t  io_supply_level,
    input  wire logic        watchdog_reset_req,
    input  wire logic        reset_pin_in,
    input  wire logic        crystal_fail_in,
    output logic             reset_pin_out,
    output logic             reset_pin_oe,
    output logic             core_run,
    output logic             io_default,
    output logic [15:0]      fetch_vector,
    output logic             fetch_start,
    output rss_clk_e         clk_source,
    output logic             irq
  );

  localparam int unsigned   CNT_W     = $clog2(POR_DELAY_CYCLES + 1);
  localparam logic [CNT_W-1:0] POR_LAST  = CNT_W'(POR_DELAY_CYCLES - 1);
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(`RSS_HOLD_CYCLES - 1);

  // True for every offset that the slave decodes
  function automatic logic reg_mapped(input logic [7:0] a);
    case (a)
      `RSS_ADDR_SYSCTL, `RSS_ADDR_DBGFLAG, `RSS_ADDR_BO_ENABLE, `RSS_ADDR_CLKCTL,
      `RSS_ADDR_IRQ_STATUS, `RSS_ADDR_IRQ_ENABLE, `RSS_ADDR_IRQ_CLEAR,
      `RSS_ADDR_RST_CAUSE: reg_mapped = 1'b1;
      default: reg_mapped = 1'b0;
    endcase
  endfunction

  // Qualified pin reset and crystal failure, both from outside the clock domain
  logic ext_reset_active;       // Pin low for the minimum width
  logic xtal_fail_active;       // Crystal monitor reports failure

  // Cleared while the device pulls the pin itself; otherwise its own low drive would
  // echo through the synchroniser and look like a pin reset right after power-on
  logic pin_qual_rstn;          // Pin qualifier reset, active low
  assign pin_qual_rstn = aresetn && !reset_pin_oe;

  rss_sync_qualify #(.MIN_CYCLES(`RSS_EXT_MIN_LOW), .ACTIVE_LOW(1'b1)) u_pin_qual (
    .aclk     (aclk),
    .aresetn  (pin_qual_rstn),
    .async_in (reset_pin_in),
    .active   (ext_reset_active)
  );

  rss_sync_qualify #(.MIN_CYCLES(`RSS_XTAL_FAIL_MIN), .ACTIVE_LOW(1'b0)) u_xtal_qual (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (crystal_fail_in),
    .active   (xtal_fail_active)
  );

  // Brownout comparators, one per supply
  logic [2:0][7:0] supply_level;  // Core, analog, I/O
  logic [2:0]      supply_below;  // Level under its alert threshold
  assign supply_level = {io_supply_level, analog_supply_level, core_supply_level};

  generate
    for (genvar i = 0; i < 3; i++)
    begin : g_bo
      assign supply_below[i] = supply_level[i] < BO_THRESHOLDS[i];
    end
  endgenerate

  // AXI4-Lite slave state
  logic [7:0]  wr_addr;         // Captured write address
  logic [31:0] wr_data;         // Captured write data
  logic [3:0]  wr_strb;         // Captured byte enables
  logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [7:0]  next_wr_addr;
  logic [31:0] next_wr_data;
  logic [3:0]  next_wr_strb;
  logic        wr_fire;         // Both halves held, response slot free
  logic        wr_lane0;        // Low byte lane is written

  // Register file
  logic        dbg_pgm_en, next_dbg_pgm_en;   // debug_program_enable
  logic [2:0]  bo_enable, next_bo_enable;     // Core, analog, I/O brownout enables
  logic [1:0]  clk_req, next_clk_req;         // Requested master clock source
  logic        xtal_failed, next_xtal_failed; // Sticky crystal failure
  logic [3:0]  irq_status, next_irq_status;   // Sticky events
  logic [3:0]  irq_enable, next_irq_enable;
  logic [3:0]  rst_cause, next_rst_cause;     // Sys, pin, watchdog, power-on
  logic [3:0]  irq_events;
  logic [3:0]  irq_clear;
  logic        sys_reset_req;                 // Software reset accepted
  logic        next_irq;
  rss_clk_e    next_clk_source;

  // Sequencer
  rss_state_e       state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic             core_below_por;
  logic             next_core_run, next_pin_oe, next_fetch_start;

  assign wr_fire  = !awready && !wready && !bvalid;
  assign wr_lane0 = wr_fire && wr_strb[0];
  assign core_below_por = core_supply_level < POR_THRESHOLD;

  // Self-clearing request; ignored unless debug program-enable is set
  assign sys_reset_req = wr_lane0 && (wr_addr == `RSS_ADDR_SYSCTL)
                         && wr_data[`RSS_SC_SWRST] && dbg_pgm_en;

  // Bus handshakes: address and data captured in either order
  always_comb
  begin
    next_awready = awready;
    next_wready  = wready;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_arready = arready;
    next_rvalid  = rvalid;
    next_rresp   = rresp;
    next_rdata   = rdata;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    if (awvalid && awready)
    begin
      next_wr_addr = awaddr;
      next_awready = 1'b0;
    end
    if (wvalid && wready)
    begin
      next_wr_data = wdata;
      next_wr_strb = wstrb;
      next_wready  = 1'b0;
    end
    if (bvalid && bready)
      next_bvalid = 1'b0;
    // Write completes only after any earlier response was taken
    if (wr_fire)
    begin
      next_bvalid  = 1'b1;
      next_bresp   = reg_mapped(wr_addr) ? 2'h0 : 2'h3;
      next_awready = 1'b1;
      next_wready  = 1'b1;
    end
    if (rvalid && rready)
    begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
    if (arvalid && arready)
    begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rresp   = reg_mapped(araddr) ? 2'h0 : 2'h3;
      case (araddr)
        `RSS_ADDR_DBGFLAG:    next_rdata = {30'h0, dbg_pgm_en, 1'b0};
        `RSS_ADDR_BO_ENABLE:  next_rdata = {29'h0, bo_enable};
        `RSS_ADDR_CLKCTL:     next_rdata = {27'h0, xtal_failed, clk_source, clk_req};
        `RSS_ADDR_IRQ_STATUS: next_rdata = {28'h0, irq_status};
        `RSS_ADDR_IRQ_ENABLE: next_rdata = {28'h0, irq_enable};
        `RSS_ADDR_RST_CAUSE:  next_rdata = {28'h0, rst_cause};
        default:              next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= 2'h0;
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rresp   <= 2'h0;
      rdata   <= 32'h0;
      wr_addr <= 8'h0;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
    end
    else
    begin
      awready <= next_awready;
      wready  <= next_wready;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      arready <= next_arready;
      rvalid  <= next_rvalid;
      rresp   <= next_rresp;
      rdata   <= next_rdata;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      wr_strb <= next_wr_strb;
    end
  end

  // Register updates; a new event wins over a clear in the same cycle
  always_comb
  begin
    next_dbg_pgm_en  = dbg_pgm_en;
    next_bo_enable   = bo_enable;
    next_clk_req     = clk_req;
    next_irq_enable  = irq_enable;
    next_xtal_failed = xtal_failed;
    irq_clear        = 4'h0;
    if (wr_lane0)
    begin
      case (wr_addr)
        `RSS_ADDR_DBGFLAG:    next_dbg_pgm_en = wr_data[`RSS_DF_PGMEN];
        `RSS_ADDR_BO_ENABLE:  next_bo_enable  = wr_data[2:0];
        `RSS_ADDR_CLKCTL:
        begin
          next_clk_req     = wr_data[1:0];
          next_xtal_failed = 1'b0;
        end
        `RSS_ADDR_IRQ_ENABLE: next_irq_enable = wr_data[3:0];
        `RSS_ADDR_IRQ_CLEAR:  irq_clear       = wr_data[3:0];
        default:              next_dbg_pgm_en = dbg_pgm_en;
      endcase
    end
    if (xtal_fail_active)
      next_xtal_failed = 1'b1;
    // Each brownout monitor alerts only through its own enable; crystal failure alerts only while the crystal is the source
    irq_events = {xtal_fail_active && (clk_source == RSS_CLK_XTAL),
                  bo_enable & supply_below};
    next_irq_status = (irq_status & ~irq_clear) | irq_events;
    next_irq = |(next_irq_status & next_irq_enable);
    // Crystal failure forces the RC oscillator; the unused code also means RC
    if (next_clk_req == RSS_CLK_XTAL && next_xtal_failed)
      next_clk_source = RSS_CLK_RC;
    else if (next_clk_req == 2'h3)
      next_clk_source = RSS_CLK_RC;
    else
      next_clk_source = rss_clk_e'(next_clk_req);
  end

  // Power-on hold returns every register to its reset value
  always_ff @(posedge aclk)
  begin
    if (!aresetn || state == RSS_ST_POR)
    begin
      dbg_pgm_en  <= 1'b0;
      bo_enable   <= `RSS_BO_EN_RESET;
      clk_req     <= RSS_CLK_RC;
      xtal_failed <= 1'b0;
      irq_status  <= `RSS_IRQ_RESET;
      irq_enable  <= `RSS_IRQ_RESET;
      irq         <= 1'b0;
      clk_source  <= RSS_CLK_RC;
    end
    else
    begin
      dbg_pgm_en  <= next_dbg_pgm_en;
      bo_enable   <= next_bo_enable;
      clk_req     <= next_clk_req;
      xtal_failed <= next_xtal_failed;
      irq_status  <= next_irq_status;
      irq_enable  <= next_irq_enable;
      irq         <= next_irq;
      clk_source  <= next_clk_source;
    end
  end

  // Reset sequencer: the power-on delay restarts while the core supply is low
  always_comb
  begin
    next_state     = state;
    next_cnt       = cnt;
    next_rst_cause = rst_cause;
    if (core_below_por)
    begin
      next_state     = RSS_ST_POR;
      next_cnt       = '0;
      next_rst_cause = `RSS_CAUSE_POR;
    end
    else
    begin
      case (state)
        RSS_ST_POR:
          if (cnt == POR_LAST)
          begin
            next_state = RSS_ST_RUN;
            next_cnt   = '0;
          end
          else
            next_cnt = cnt + 1'b1;
        RSS_ST_RUN:
          if (watchdog_reset_req || ext_reset_active || sys_reset_req)
          begin
            next_state     = RSS_ST_HOLD;
            next_cnt       = '0;
            next_rst_cause = {sys_reset_req, ext_reset_active, watchdog_reset_req, 1'b0};
          end
        RSS_ST_HOLD:
          // Hold lasts while the pin stays low or the watchdog request stays high, then a short fixed tail
          if (ext_reset_active || watchdog_reset_req)
            next_cnt = '0;
          else if (cnt == HOLD_LAST)
          begin
            next_state = RSS_ST_RUN;
            next_cnt   = '0;
          end
          else
            next_cnt = cnt + 1'b1;
        default:
          next_state = RSS_ST_POR;
      endcase
    end
    next_core_run    = (next_state == RSS_ST_RUN);
    next_pin_oe      = (next_state == RSS_ST_POR);
    next_fetch_start = next_core_run && !core_run;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state         <= RSS_ST_POR;
      cnt           <= '0;
      rst_cause     <= `RSS_CAUSE_POR;
      core_run      <= 1'b0;
      io_default    <= 1'b1;
      reset_pin_oe  <= 1'b1;
      reset_pin_out <= 1'b0;
      fetch_start   <= 1'b0;
      fetch_vector  <= `RSS_RESET_VECTOR;
    end
    else
    begin
      state         <= next_state;
      cnt           <= next_cnt;
      rst_cause     <= next_rst_cause;
      core_run      <= next_core_run;
      io_default    <= !next_core_run;
      reset_pin_oe  <= next_pin_oe;
      reset_pin_out <= 1'b0;
      fetch_start   <= next_fetch_start;
      fetch_vector  <= `RSS_RESET_VECTOR;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_pin_held_low;
    !reset_pin_in [*8];
  endsequence

  sequence s_por_exit;
    $fell(reset_pin_oe);
  endsequence

  a_reset_no_exec: assert property ((state != RSS_ST_RUN) |-> !core_run && io_default)
    else $error("core runs during reset");
  a_fetch_vector: assert property (fetch_start |-> core_run && fetch_vector == 16'h8000)
    else $error("fetch not at reset vector");
  a_pin_reset: assert property (s_pin_held_low |-> !core_run)
    else $error("held reset pin ignored");
  a_sw_reset_gate: assert property (sys_reset_req |-> dbg_pgm_en ##1 !core_run)
    else $error("software reset mishandled");
  a_bo_alert_set: assert property (bo_enable[0] && supply_below[0] && state != RSS_ST_POR
                                   |=> irq_status[0])
    else $error("core brownout not flagged");
  a_bo_own_enable: assert property (!bo_enable[1] && !irq_status[1] |=> !irq_status[1])
    else $error("disabled monitor raised alert");
  a_por_pin_drive: assert property ((state == RSS_ST_POR) |-> reset_pin_oe && !reset_pin_out)
    else $error("pin not driven low at power-on");
  a_por_delay_len: assert property (s_por_exit |-> $past(cnt) == POR_LAST && fetch_start)
    else $error("power-on delay length wrong");
  a_rc_on_fail: assert property (xtal_fail_active && state != RSS_ST_POR
                                 |=> clk_source != RSS_CLK_XTAL)
    else $error("crystal failure kept crystal clock");
  a_clk_rc_boot: assert property (s_por_exit |-> clk_source == RSS_CLK_RC)
    else $error("startup clock not RC");

endmodule

/* verif/rss_far_side.sv */
// Far side of the supervisor: the board reset driver and the three supplies
module rss_far_side
  import rss_pkg::*;
  (
    input  wire logic aclk,
    input  wire logic reset_pin_out,
    input  wire logic reset_pin_oe,
    output logic      reset_pin_in,
    output rss_level_t core_supply_level,
    output rss_level_t analog_supply_level,
    output rss_level_t io_supply_level
  );
  timeunit 1ns;
  timeprecision 1ns;

  logic pull_low; // Board driver is pulling the pin low

  // Wire level: the device driver wins, else the board driver, else the pull-up
  assign reset_pin_in = reset_pin_oe ? reset_pin_out : !pull_low;

  // Supplies start healthy so power-on hold can complete
  initial
  begin
    pull_low = 1'b0;
    core_supply_level = 8'hff;
    analog_supply_level = 8'hff;
    io_supply_level = 8'hff;
  end

  // Low pulse of whole cycles; only four or more count as a request
  task automatic pulse_pin(input int unsigned n);
    @(posedge aclk);
    pull_low <= 1'b1;
    repeat (n) @(posedge aclk);
    pull_low <= 1'b0;
  endtask

  // New supply codes, changed just after a rising edge
  task automatic set_levels(input rss_level_t c, input rss_level_t a, input rss_level_t i);
    @(posedge aclk);
    core_supply_level <= c;
    analog_supply_level <= a;
    io_supply_level <= i;
  endtask
endmodule

/* verif/reset_and_supply_supervisor_tb.sv */
`include "rss_params.svh"

module reset_and_supply_supervisor_tb;
  import rss_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int unsigned POR_CYC = 8; // Shortened power-on delay

  logic        aclk, aresetn;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp;
  rss_level_t  core_lvl, ana_lvl, io_lvl;
  logic        wdog, pin_in, xtal_fail, pin_out, pin_oe;
  logic        core_run, io_default, fetch_start, irq;
  logic [15:0] fetch_vector;
  rss_clk_e    clk_source;
  int          mismatches, n_tests;
  logic [1:0]  rsp;   // Last bus response code
  logic [31:0] rd;    // Last read data
  int          n;     // Cycle count of the last wait
  logic [2:0]  mask;  // Brownout enables under test

  rss_supervisor #(.POR_DELAY_CYCLES(POR_CYC)) dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .core_supply_level(core_lvl), .analog_supply_level(ana_lvl), .io_supply_level(io_lvl),
    .watchdog_reset_req(wdog), .reset_pin_in(pin_in), .crystal_fail_in(xtal_fail),
    .reset_pin_out(pin_out), .reset_pin_oe(pin_oe), .core_run(core_run),
    .io_default(io_default), .fetch_vector(fetch_vector), .fetch_start(fetch_start),
    .clk_source(clk_source), .irq(irq));

  rss_far_side far (
    .aclk(aclk), .reset_pin_out(pin_out), .reset_pin_oe(pin_oe), .reset_pin_in(pin_in),
    .core_supply_level(core_lvl), .analog_supply_level(ana_lvl), .io_supply_level(io_lvl));

  // 50 MHz system clock
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // Verdict and end of run, the one exit point
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Single comparison point; case equality so unknowns never match
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Handshakes are observed at the falling edge, where outputs have settled
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw_hs, w_hs, b_hs;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (int i = 0; i < 64; i++)
    begin
      @(negedge aclk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid && bready;
      rsp = bresp;
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (b_hs)
      begin
        bready <= 1'b0;
        return;
      end
    end
    mismatches++;
    summarize();
  endtask

  // Read one word; rready is held until rvalid is seen
  task automatic axr(input logic [7:0] a);
    logic ar_hs;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (int i = 0; i < 64; i++)
    begin
      @(negedge aclk);
      ar_hs = arvalid && arready;
      rd = rdata;
      rsp = rresp;
      @(posedge aclk);
      if (ar_hs) arvalid <= 1'b0;
      if (rvalid)
      begin
        rready <= 1'b0;
        return;
      end
    end
    mismatches++;
    summarize();
  endtask

  // Bounded wait for core_run; counts falling edges until it reaches lvl
  task automatic wait_run(input logic lvl, input int lim);
    for (n = 1; n <= lim; n++)
    begin
      @(negedge aclk);
      if (core_run === lvl) return;
    end
    mismatches++;
    summarize();
  endtask

  // Expected status: a monitor flags only if enabled and below its threshold
  function automatic logic [31:0] bo_exp(input logic [2:0] en, input rss_level_t c,
                                         input rss_level_t a, input rss_level_t i);
    return {29'h0, en & {i < 8'h70, a < 8'h70, c < 8'h70}};
  endfunction

  // Expected clock control word: request, active source, failure flag
  function automatic logic [31:0] clk_exp(input logic [1:0] rq, input logic [1:0] act,
                                          input logic fl);
    return {27'h0, fl, act, rq};
  endfunction

  // After a reset clears: restart at the vector with a fetch pulse, cause recorded
  task automatic restart_check(input logic [3:0] cause);
    wait_run(1'b1, 60);
    chk(fetch_start, 1'b1, "fetch pulse");
    chk(fetch_vector, 16'h8000, "vector");
    axr(`RSS_ADDR_RST_CAUSE);
    chk(rd, {28'h0, cause}, "reset cause");
  endtask

  initial
  begin
    logic [7:0] ra [8];
    logic [31:0] rv [8];
    rss_level_t c, a, i;
    ra = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
    rv = '{0, 0, 0, 32'h5, 0, 0, 0, 32'h1};
    void'($urandom(68));
    aresetn = 1'b0; awaddr = 8'h0; araddr = 8'h0; wdata = 32'h0; wstrb = 4'hf;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    wdog = 1'b0; xtal_fail = 1'b0;
    repeat (20) @(posedge aclk);
    @(negedge aclk);
    // Power-up: core idle, pin driven low, RC clock
    chk({core_run, io_default, pin_oe, pin_out}, 4'h6, "power-up outputs");
    chk(clk_source, RSS_CLK_RC, "startup clock");
    @(posedge aclk);
    aresetn <= 1'b1;
    // A supply dip restarts the power-on delay from the rise
    far.set_levels(8'h50, 8'hff, 8'hff);
    @(negedge aclk);
    chk(pin_oe, 1'b1, "pin held low");
    far.set_levels(8'hff, 8'hff, 8'hff);
    wait_run(1'b1, 40);
    chk(n >= POR_CYC && n <= POR_CYC + 2, 1'b1, "power-on delay");
    chk({pin_oe, fetch_start, clk_source}, 4'h5, "leaving power-on");
    // Reset values of every register, then an unmapped read and an unmapped write
    foreach (ra[k])
    begin
      axr(ra[k]);
      chk(rd, rv[k], "reset value");
    end
    axr(8'h20);
    chk(rsp, 2'h3, "unmapped read code");
    chk(rd, 32'h0, "unmapped read data");
    axw(8'h24, 32'hffff_ffff);
    chk(rsp, 2'h3, "unmapped write");
    // Brownout monitors with random enable sets, each gated by its own bit
    axw(`RSS_ADDR_IRQ_ENABLE, 32'hf);
    repeat (4)
    begin
      mask = 3'($urandom);
      c = 8'h61 + 8'($urandom % 32);
      a = 8'($urandom);
      i = 8'($urandom);
      axw(`RSS_ADDR_BO_ENABLE, {29'h0, mask});
      far.set_levels(c, a, i);
      axr(`RSS_ADDR_IRQ_STATUS);
      chk(rd, bo_exp(mask, c, a, i), "brownout status");
      chk(irq, |bo_exp(mask, c, a, i), "brownout irq");
      far.set_levels(8'hff, 8'hff, 8'hff);
      axw(`RSS_ADDR_IRQ_CLEAR, 32'hf);
      axr(`RSS_ADDR_IRQ_STATUS);
      chk(rd, 32'h0, "cleared status");
      chk(irq, 1'b0, "cleared irq");
    end
    // Clock sources: crystal, failure fallback, external input
    axw(`RSS_ADDR_CLKCTL, 32'h0);
    chk(clk_source, RSS_CLK_XTAL, "crystal selected");
    @(posedge aclk);
    xtal_fail <= 1'b1;
    repeat (6) @(posedge aclk);
    xtal_fail <= 1'b0;
    axr(`RSS_ADDR_CLKCTL);
    chk(rd, clk_exp(2'h0, 2'h1, 1'b1), "crystal fallback");
    chk(irq, 1'b1, "crystal fail irq");
    axw(`RSS_ADDR_IRQ_CLEAR, 32'hf);
    axw(`RSS_ADDR_CLKCTL, 32'h2);
    axr(`RSS_ADDR_CLKCTL);
    chk(rd, clk_exp(2'h2, 2'h2, 1'b0), "external clock");
    // The spare request code falls back to the RC oscillator
    axw(`RSS_ADDR_CLKCTL, 32'h3);
    axr(`RSS_ADDR_CLKCTL);
    chk(rd, clk_exp(2'h3, 2'h1, 1'b0), "spare clock code");
    // Software reset refused without the debug enable, then honoured
    axw(`RSS_ADDR_SYSCTL, 32'h1);
    repeat (4) @(negedge aclk);
    chk(core_run, 1'b1, "refused soft reset");
    axw(`RSS_ADDR_DBGFLAG, 32'h2);
    axw(`RSS_ADDR_SYSCTL, 32'h1);
    wait_run(1'b0, 8);
    chk(io_default, 1'b1, "io defaults");
    restart_check(4'h8);
    // Watchdog request
    @(posedge aclk);
    wdog <= 1'b1;
    repeat (3) @(posedge aclk);
    wdog <= 1'b0;
    restart_check(4'h2);
    // Pin pulse one cycle short is ignored
    far.pulse_pin(3);
    for (int k = 0; k < 14; k++)
    begin
      @(negedge aclk);
      chk(core_run, 1'b1, "short pin pulse");
    end
    // Random pulse of legal length resets without the device driving the pin
    far.pulse_pin(4 + $urandom % 6);
    wait_run(1'b0, 12);
    chk({pin_oe, io_default}, 2'h1, "pin reset");
    restart_check(4'h4);
    summarize();
  end
endmodule
